// ==== hw/hfc_pkg.sv ====
package hfc_pkg;
  localparam int HFC_BIT_ABORT = 3;
  localparam int HFC_BIT_NO_CRC = 4;
  localparam int HFC_BIT_NO_REP = 5;
  localparam logic [7:0] HFC_CTRL_RESET = 8'h00;
  localparam logic [7:0] HFC_CTRL_WMASK = 8'h38;
  localparam logic [1:0] HFC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] HFC_ADDR_STAT = 2'h1;
  localparam logic [1:0] HFC_ADDR_FSTAT = 2'h2;
  localparam logic [7:0] HFC_STA_GOOD = 8'h00;
  localparam logic [7:0] HFC_STA_ABORT = 8'hff;
  localparam logic [7:0] HFC_STA_CRC = 8'h01;
  localparam int HFC_ABORT_ONES = 16;
  localparam int HFC_RX_ABORT_ONES = 7;
  localparam int HFC_FLAG_ONES = 6;
  localparam logic [7:0] HFC_FLAG = 8'h7e;
  localparam logic [15:0] HFC_CRC_INIT = 16'hffff;
  localparam logic [15:0] HFC_CRC_POLY = 16'h8408;
  localparam logic [15:0] HFC_CRC_GOOD = 16'hf0b8;
  typedef struct packed {
    logic abort_en;
    logic no_crc;
    logic no_rep;
  } hfc_cfg_t;
endpackage

// ==== hw/hfc_crc16.sv ====
`timescale 1ns/100ps
`default_nettype none
module hfc_crc16
  import hfc_pkg::*;
(
  input wire logic [15:0] crc,
  input wire logic din,
  output logic [15:0] next_crc
);
  always_comb
  begin
    if (crc[0] ^ din)
      next_crc = (crc >> 1) ^ HFC_CRC_POLY;
    else
      next_crc = crc >> 1;
  end
endmodule
`default_nettype wire

// ==== hw/hfc_framer.sv ====
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module hfc_framer
  import hfc_pkg::*;
#(
  parameter int CW = 8
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic hdlc_mode,
  input wire logic [CW-1:0] byte_input_counter,
  input wire logic [CW-1:0] byte_output_counter,
  input wire logic [CW-1:0] frame_input_counter,
  input wire logic [CW-1:0] frame_output_counter,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_take,
  input wire logic tx_bit_req,
  output logic tx_bit,
  input wire logic d_channel,
  input wire logic contention_lost,
  input wire logic rx_bit_pin,
  input wire logic rx_bit_en,
  output logic [7:0] rx_byte,
  output logic rx_byte_vld,
  output logic [7:0] rx_status,
  output logic rx_status_vld,
  output logic rx_bit_out
);
  typedef enum {TX_IDLE, TX_DATA, TX_CRC, TX_CLOSE, TX_ABORT} hfc_tx_t;
  hfc_tx_t tx_st;
  hfc_cfg_t cfg;
  logic [7:0] ctrl_hi;
  logic fifo_err;
  logic [7:0] last_status;
  logic [7:0] sh;
  logic [3:0] bitn;
  logic [2:0] ones;
  logic [4:0] abcnt;
  logic [15:0] tcrc, tcrc_n, rcrc, rcrc_n;
  logic in_frame;
  logic [7:0] frame_copy;
  logic [1:0] crc_bytes;
  logic rx_s1, rx_s2, en_s1, en_s2;
  logic [7:0] rsh;
  logic [2:0] rones;
  logic [3:0] rcnt;
  logic rframe, raborted, rgot;
  logic [15:0] rcrc_byte;
  logic tx_cur, underrun, use_hdlc;

  assign use_hdlc = hdlc_mode;
  assign underrun = (byte_input_counter == byte_output_counter)
    && (frame_input_counter == frame_output_counter);
  assign tx_cur = sh[0];

  hfc_crc16 u_tcrc (.crc(tcrc), .din(tx_cur), .next_crc(tcrc_n));
  hfc_crc16 u_rcrc (.crc(rcrc), .din(rx_s2), .next_crc(rcrc_n));

  // Register port; reserved bits 7:6 kept zero regardless of writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg <= '0;
      ctrl_hi <= HFC_CTRL_RESET;
    end
    else if (ce && wr && addr == HFC_ADDR_CTRL)
    begin
      ctrl_hi <= wdata & HFC_CTRL_WMASK;
      cfg.abort_en <= wdata[HFC_BIT_ABORT];
      cfg.no_crc <= wdata[HFC_BIT_NO_CRC];
      cfg.no_rep <= wdata[HFC_BIT_NO_REP];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (ce && rd)
    begin
      case (addr)
        HFC_ADDR_CTRL: rdata <= ctrl_hi;
        HFC_ADDR_STAT: rdata <= {7'h00, fifo_err};
        HFC_ADDR_FSTAT: rdata <= last_status;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Error flag: underrun set wins over read-clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fifo_err <= 1'b0;
    else if (ce)
    begin
      if (tx_st == TX_DATA && tx_bit_req && bitn == 4'h7 && !frame_copy[0] && underrun)
        fifo_err <= 1'b1;
      else if (rd && addr == HFC_ADDR_STAT)
        fifo_err <= 1'b0;
    end
  end

  // Transmit: frame_copy[0] marks the last byte of a frame
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_st <= TX_IDLE;
      sh <= HFC_FLAG;
      bitn <= 4'h0;
      ones <= 3'h0;
      abcnt <= 5'h0;
      tcrc <= HFC_CRC_INIT;
      tx_bit <= 1'b1;
      tx_take <= 1'b0;
      in_frame <= 1'b0;
      frame_copy <= 8'h00;
      crc_bytes <= 2'h0;
    end
    else if (ce)
    begin
      tx_take <= 1'b0;
      if (tx_bit_req)
      begin
        if (!use_hdlc)
        begin
          tx_bit <= tx_cur;
          sh <= {1'b1, sh[7:1]};
          bitn <= bitn + 4'h1;
          if (bitn == 4'h7)
          begin
            bitn <= 4'h0;
            sh <= underrun ? 8'hff : tx_byte;
            tx_take <= !underrun;
          end
        end
        else if (tx_st == TX_ABORT)
        begin
          tx_bit <= 1'b1;
          abcnt <= abcnt + 5'h1;
          if (abcnt == 5'(HFC_ABORT_ONES - 1))
          begin
            tx_st <= TX_IDLE;
            abcnt <= 5'h0;
          end
        end
        else if ((tx_st == TX_DATA || tx_st == TX_CRC) && ones == 3'(HFC_FLAG_ONES - 1))
        begin
          // Stuffed zero; shifter and bit count hold so no data bit is lost
          tx_bit <= 1'b0;
          ones <= 3'h0;
        end
        else
        begin
          tx_bit <= tx_cur;
          ones <= tx_cur ? ones + 3'h1 : 3'h0;
          if (tx_st == TX_DATA)
            tcrc <= tcrc_n;
          sh <= {1'b1, sh[7:1]};
          bitn <= bitn + 4'h1;
          if (bitn == 4'h7)
          begin
            bitn <= 4'h0;
            case (tx_st)
              TX_IDLE, TX_CLOSE:
              begin
                tcrc <= HFC_CRC_INIT;
                if (!underrun)
                begin
                  tx_st <= TX_DATA;
                  sh <= tx_byte;
                  frame_copy <= {7'h00, tx_last};
                  tx_take <= 1'b1;
                  in_frame <= 1'b1;
                end
                else
                begin
                  tx_st <= TX_IDLE;
                  sh <= HFC_FLAG;
                end
              end
              TX_DATA:
              begin
                if (contention_lost && d_channel)
                begin
                  tx_st <= TX_ABORT;
                  sh <= HFC_FLAG;
                  in_frame <= 1'b0;
                end
                else if (frame_copy[0])
                begin
                  tx_st <= cfg.no_crc ? TX_CLOSE : TX_CRC;
                  sh <= cfg.no_crc ? HFC_FLAG : ~tcrc_n[7:0];
                  crc_bytes <= 2'h1;
                end
                else if (underrun)
                begin
                  tx_st <= cfg.abort_en ? TX_ABORT : TX_CLOSE;
                  sh <= HFC_FLAG;
                  in_frame <= 1'b0;
                end
                else
                begin
                  sh <= tx_byte;
                  frame_copy <= {7'h00, tx_last};
                  tx_take <= 1'b1;
                end
              end
              TX_CRC:
              begin
                crc_bytes <= crc_bytes + 2'h1;
                sh <= (crc_bytes == 2'h1) ? ~tcrc[15:8] : HFC_FLAG;
                if (crc_bytes == 2'h2)
                begin
                  tx_st <= TX_CLOSE;
                  in_frame <= 1'b0;
                end
              end
              default: tx_st <= TX_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end
    else if (ce)
    begin
      rx_s1 <= rx_bit_pin;
      rx_s2 <= rx_s1;
      en_s1 <= rx_bit_en;
      en_s2 <= en_s1;
    end
  end

  // Receive deframer; contention retry left to the D-channel arbiter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsh <= 8'h00;
      rones <= 3'h0;
      rcnt <= 4'h0;
      rframe <= 1'b0;
      raborted <= 1'b0;
      rgot <= 1'b0;
      rcrc_byte <= HFC_CRC_INIT;
      rcrc <= HFC_CRC_INIT;
      rx_byte <= 8'h00;
      rx_byte_vld <= 1'b0;
      rx_status <= 8'h00;
      rx_status_vld <= 1'b0;
      rx_bit_out <= 1'b1;
      last_status <= 8'h00;
    end
    else if (ce)
    begin
      rx_byte_vld <= 1'b0;
      rx_status_vld <= 1'b0;
      if (en_s2)
      begin
        rx_bit_out <= rx_s2;
        if (!use_hdlc)
        begin
          rsh <= {rx_s2, rsh[7:1]};
          rcnt <= rcnt + 4'h1;
          if (rcnt == 4'h7)
          begin
            rcnt <= 4'h0;
            rx_byte <= {rx_s2, rsh[7:1]};
            rx_byte_vld <= 1'b1;
          end
        end
        else if (rx_s2)
        begin
          if (rones != 3'(HFC_RX_ABORT_ONES - 1))
            rones <= rones + 3'h1;
          else if (rframe)
          begin
            rframe <= 1'b0;
            raborted <= 1'b1;
          end
          rsh <= {1'b1, rsh[7:1]};
          rcrc <= rcrc_n;
          rcnt <= rcnt + 4'h1;
        end
        else
        begin
          rones <= 3'h0;
          if (rones == 3'(HFC_FLAG_ONES))
          begin
            // Back-to-back flags carry no bytes and report nothing
            if (rgot || raborted)
            begin
              rx_status_vld <= 1'b1;
              if (raborted)
              begin
                rx_status <= cfg.abort_en ? HFC_STA_ABORT : HFC_STA_CRC;
                last_status <= cfg.abort_en ? HFC_STA_ABORT : HFC_STA_CRC;
              end
              else
              begin
                rx_status <= (rcrc_byte == HFC_CRC_GOOD) ? HFC_STA_GOOD : HFC_STA_CRC;
                last_status <= (rcrc_byte == HFC_CRC_GOOD) ? HFC_STA_GOOD : HFC_STA_CRC;
              end
            end
            rframe <= 1'b1;
            raborted <= 1'b0;
            rgot <= 1'b0;
            rcrc_byte <= HFC_CRC_INIT;
            rcrc <= HFC_CRC_INIT;
            rcnt <= 4'h0;
          end
          else if (rones != 3'(HFC_FLAG_ONES - 1))
          begin
            rsh <= {1'b0, rsh[7:1]};
            rcrc <= rcrc_n;
            rcnt <= rcnt + 4'h1;
          end
        end
        if (use_hdlc && rframe && rcnt == 4'h7 && !(rx_s2 == 1'b0 && rones >= 3'(HFC_FLAG_ONES - 1)))
        begin
          rcnt <= 4'h0;
          rx_byte <= {rx_s2, rsh[7:1]};
          rx_byte_vld <= 1'b1;
          rgot <= 1'b1;
          // Snapshot at byte end so closing flag bits never reach the check
          rcrc_byte <= rcrc_n;
        end
      end
    end
  end

  AST_ABORT_ONES: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && tx_bit_req && tx_st == TX_ABORT && abcnt == 5'h0 && use_hdlc)
      |=> tx_bit == 1'b1)
    else $error("abort does not send ones");
  AST_ERR_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && tx_st == TX_DATA && tx_bit_req && bitn == 4'h7 && !frame_copy[0] && underrun)
      |=> fifo_err)
    else $error("underrun flag not set");
  AST_STATUS_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    (rx_status_vld && !cfg.abort_en) |-> rx_status != HFC_STA_ABORT)
    else $error("abort code while indication off");
  AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_hi[7:6] == 2'h0)
    else $error("reserved bits nonzero");
  AST_ABORT_END: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && tx_bit_req && use_hdlc && tx_st == TX_ABORT && abcnt == 5'(HFC_ABORT_ONES - 1))
      |=> tx_st == TX_IDLE && tx_bit)
    else $error("abort run length wrong");
  AST_RX_MIRROR: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && en_s2) |=> rx_bit_out == $past(rx_s2))
    else $error("line bit not mirrored");
endmodule
`default_nettype wire

// ==== bench/hfc_remote.sv ====
`timescale 1ns/100ps
`default_nettype none
module hfc_remote
(
  input wire logic clk,
  input wire logic [3:0] period,
  input wire logic run_clr,
  input wire logic tx_bit,
  output logic tx_bit_req,
  output logic rx_bit_pin,
  output logic rx_bit_en,
  output logic [7:0] max_run
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] run = 8'h00;
  initial
  begin
    tx_bit_req = 1'b0;
    rx_bit_pin = 1'b1;
    rx_bit_en = 1'b0;
    max_run = 8'h00;
  end
  // Echo station: every line bit comes back, so our frames loop to our receiver
  always @(posedge clk)
  begin
    cnt <= (cnt >= period) ? 4'h0 : cnt + 4'h1;
    tx_bit_req <= (cnt == 4'h0);
    // Strobe lands four cycles after the pin changes, so the pin is steady across the synchroniser
    rx_bit_en <= (cnt == 4'h3);
    if (cnt == period)
    begin
      rx_bit_pin <= tx_bit;
      run <= tx_bit ? run + 8'h01 : 8'h00;
      if (tx_bit && run + 8'h01 > max_run)
        max_run <= run + 8'h01;
    end
    if (run_clr)
      max_run <= 8'h00;
  end
endmodule
`default_nettype wire

// ==== bench/hfc_framer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module hfc_framer_tb;
  import hfc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hdlc_mode = 1'b1;
  logic last_mark = 1'b0;
  logic d_channel = 1'b0;
  logic lost = 1'b0;
  logic run_clr = 1'b0;
  logic [3:0] period = 4'h9;
  logic [7:0] bin = 8'h00, bout = 8'h00, fin = 8'h00, fout = 8'h00;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] rdata, rx_byte, rx_status, max_run, sta;
  logic tx_take, tx_bit_req, tx_bit, rx_bit_pin, rx_bit_en, rx_byte_vld, rx_status_vld;
  wire tx_last = last_mark && (bout == bin - 8'h01);
  int num_errors = 0;
  int cmp_count = 0;
  int n_sta = 0;
  logic [7:0] rxq [$];
  logic [7:0] cfg [5] = '{8'h00, 8'h10, 8'h08, 8'h18, 8'h28};
  logic dn [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic ct [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  always #5 clk = ~clk;

  hfc_framer dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .hdlc_mode(hdlc_mode), .byte_input_counter(bin),
    .byte_output_counter(bout), .frame_input_counter(fin), .frame_output_counter(fout),
    .tx_byte(mem[bout]), .tx_last(tx_last), .tx_take(tx_take), .tx_bit_req(tx_bit_req),
    .tx_bit(tx_bit), .d_channel(d_channel), .contention_lost(lost), .rx_bit_pin(rx_bit_pin),
    .rx_bit_en(rx_bit_en), .rx_byte(rx_byte), .rx_byte_vld(rx_byte_vld),
    .rx_status(rx_status), .rx_status_vld(rx_status_vld), .rx_bit_out());

  hfc_remote far_u (.clk(clk), .period(period), .run_clr(run_clr), .tx_bit(tx_bit),
    .tx_bit_req(tx_bit_req), .rx_bit_pin(rx_bit_pin), .rx_bit_en(rx_bit_en),
    .max_run(max_run));

  // Host side of the FIFO: output counters follow what the framer consumes
  always @(posedge clk)
  begin
    if (rx_status_vld)
    begin
      sta <= rx_status;
      n_sta <= n_sta + 1;
    end
    if (rx_byte_vld)
      rxq.push_back(rx_byte);
    if (tx_take)
    begin
      bout <= bout + 8'h01;
      if (tx_last)
        fout <= fout + 8'h01;
    end
  end

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Frame left open (done low) runs the FIFO dry in mid-frame
  task automatic load(input int n, input logic done);
    for (int i = 0; i < n; i++)
      mem[8'(bin + i)] <= 8'($urandom);
    rxq = {};
    @(posedge clk);
    run_clr <= 1'b0;
    last_mark <= done;
    bin <= bin + 8'(n);
    if (done)
      fin <= fin + 8'h01;
  endtask

  task automatic wait_out(input logic [7:0] target);
    int t;
    t = 0;
    while (bout != target && t < 20000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 20000)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic wait_sta(input int k);
    int t;
    t = 0;
    while (n_sta < k && t < 20000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 20000)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  function automatic logic [7:0] exp_sta(input logic [7:0] c, input logic done, input logic cut);
    if (!done || cut)
      return c[HFC_BIT_ABORT] ? HFC_STA_ABORT : HFC_STA_CRC;
    return c[HFC_BIT_NO_CRC] ? HFC_STA_CRC : HFC_STA_GOOD;
  endfunction

  initial
  begin
    logic [7:0] v;
    logic [7:0] s0;
    int k;
    int n;
    int c0;
    void'($urandom(32'hf925));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rreg(HFC_ADDR_CTRL, v);
    `CHK("ctrl reset", HFC_CTRL_RESET, v)
    rreg(HFC_ADDR_STAT, v);
    `CHK("stat reset", 8'h00, v)
    // Reserved bits written high on purpose: they must not stick
    wreg(HFC_ADDR_CTRL, 8'hff);
    rreg(HFC_ADDR_CTRL, v);
    `CHK("ctrl mask", HFC_CTRL_WMASK, v)
    rreg(2'h3, v);
    `CHK("unmapped", 8'h00, v)
    for (int i = 0; i < 10; i++)
    begin
      k = i % 5;
      n = 2 + $urandom % 4;
      period <= 4'h8 + 4'($urandom % 8);
      rreg(HFC_ADDR_STAT, v);
      wreg(HFC_ADDR_CTRL, cfg[k]);
      run_clr <= 1'b1;
      s0 = bin;
      c0 = n_sta;
      load(n, dn[k]);
      if (ct[k])
      begin
        d_channel <= 1'b1;
        wait_out(s0 + 8'h02);
        lost <= 1'b1;
      end
      wait_sta(c0 + 1);
      lost <= 1'b0;
      d_channel <= 1'b0;
      `CHK("rx status", exp_sta(cfg[k], dn[k], ct[k]), sta)
      rreg(HFC_ADDR_FSTAT, v);
      `CHK("status reg", exp_sta(cfg[k], dn[k], ct[k]), v)
      if (!dn[k])
      begin
        `CHK("abort ones", 1'b1, max_run >= 8'h10)
        rreg(HFC_ADDR_STAT, v);
        `CHK("fifo err", 1'b1, v[0])
      end
      else if (!ct[k])
        for (int j = 0; j < n; j++)
          `CHK("rx byte", mem[8'(s0 + j)], rxq[j])
      // Remainder after contention and its closing flag must clear the line
      wait_out(bin);
      repeat (800) @(posedge clk);
      bout <= bin;
      fout <= fin;
    end
    wreg(HFC_ADDR_CTRL, 8'h00);
    hdlc_mode <= 1'b0;
    s0 = bin;
    c0 = n_sta;
    load(3, 1'b0);
    wait_out(s0 + 8'h03);
    `CHK("no framing", c0, n_sta)
    end_sim();
  end
endmodule
`default_nettype wire
